// >>> hdl/bcc_consts.vh
// Contract
// - The counter is 24 bits and saturates at two to the 24 minus one.
// - Edge tally counts up from zero and copies on active gate edges.
// - With active-low polarity, edge tally captures on every falling gate edge.
// - Edge tally holds while the gate stays at its inactive level at arming.
// - The count input selects timebases, function pins or sibling terminal count.
// - Interval mode measures between successive same-polarity gate edges, rising by default.
// - Measurement modes default to the 20 MHz timebase, one 50 ns tick.
// - Interval mode starts at zero, stores on active edges, restarts at zero.
// - Captures fill the programmed entry count, then the counter disarms itself.
// - The 100 kHz timebase gives longer range at coarser resolution.
// - Active-low polarity makes interval mode measure between falling gate edges.
// - An external timebase on a function pin counts once selected and polarised.
// - The sibling counter terminal count is selectable as count input.
// - Half-interval mode measures between consecutive gate edges of either polarity.
// - Half-interval mode stores on any gate edge and restarts from zero.
// - Width mode measures pulses of the selected polarity, active high by default.
// - Width mode stores at pulse end and restarts at the next pulse start.
// - Counting begins at arming, so the first value may be partial; tally and width modes start then only if the gate is active.
// - The armed indication stays high during acquisition and drops at completion.
// - The count input edge is selectable, falling instead of the default rising.
`ifndef BCC_CONSTS_VH
`define BCC_CONSTS_VH

// Counter and data width.
`define BCC_CNT_W 24
`define BCC_CNT_MAX 24'hFFFFFF

// Acquisition modes.
`define BCC_MODE_TALLY 2'h0
`define BCC_MODE_INTERVAL 2'h1
`define BCC_MODE_HALF 2'h2
`define BCC_MODE_WIDTH 2'h3

// Count input selections; codes below 8 pick a function pin.
`define BCC_SRC_FAST 4'h8
`define BCC_SRC_SLOW 4'h9
`define BCC_SRC_SIBLING 4'hA
`define BCC_SRC_PIN_BIT 3

// Edge and polarity choices.
`define BCC_RISING_EDGE 1'h0
`define BCC_FALLING_EDGE 1'h1
`define BCC_ACTIVE_HIGH 1'h0
`define BCC_ACTIVE_LOW 1'h1

// Timing: clock rate and timebase rates in hertz.
`define BCC_CLK_HZ 20000000
`define BCC_FAST_HZ 20000000
`define BCC_SLOW_HZ 100000
`define BCC_FAST_DIV (`BCC_CLK_HZ / `BCC_FAST_HZ)
`define BCC_SLOW_DIV (`BCC_CLK_HZ / `BCC_SLOW_HZ)
`define BCC_DIV_W 8
// Last divider count of a slow tick period, sized to the divider.
`define BCC_SLOW_LAST 8'hC7

// Reset values.
`define BCC_CNT_RST 24'h000000

`endif

// >>> hdl/bcc_counter.v
`timescale 1ns/1ps
`include "bcc_consts.vh"

module bcc_counter (
  // Clock, reset and enable.
  input wire MCLK_I,
  input wire ARST_N_I,
  input wire CE_I,
  // Configuration, latched at arming.
  input wire [1:0] MODE_I,
  input wire [3:0] COUNT_INPUT_SELECT_I,
  input wire COUNT_INPUT_EDGE_I,
  input wire [2:0] CAPTURE_INPUT_SELECT_I,
  input wire CAPTURE_INPUT_EDGE_I,
  input wire [23:0] BUF_ENTRIES_I,
  // Actions.
  input wire ARM_ACTION_I,
  input wire RESET_ACTION_I,
  // Connector side.
  input wire [7:0] FUNC_PIN_I,
  input wire SIBLING_TC_I,
  // Status.
  output reg ARMED_O,
  output reg [23:0] COUNT_O,
  output reg [23:0] ENTRIES_DONE_O,
  output reg TC_REACHED_O,
  output reg OVERRUN_O,
  // Capture stream.
  output wire [23:0] DATA_O,
  output wire DATA_VALID_O,
  input wire DATA_READY_I
);

  // Edge of a registered level, rising or falling as asked.
  function edge_seen;
    input prev;
    input cur;
    input fall;
    begin
      edge_seen = fall ? (prev & ~cur) : (~prev & cur);
    end
  endfunction

  // Pick the raw count input level for a selection code.
  function src_level;
    input [3:0] sel;
    input [7:0] pins;
    input sib;
    begin
      if (!sel[`BCC_SRC_PIN_BIT]) begin
        src_level = pins[sel[2:0]];
      end else begin
        src_level = sib;
      end
    end
  endfunction

  localparam [`BCC_DIV_W-1:0] SLOW_LAST = `BCC_SLOW_LAST;

  // Latched configuration.
  reg [1:0] mode_q;
  reg [3:0] src_sel_q;
  reg src_fall_q;
  reg [2:0] gate_sel_q;
  reg gate_low_q;
  reg [23:0] target_q;

  // Running state.
  reg [23:0] cnt_q;
  reg [23:0] cnt_d;
  reg run_q;
  reg run_d;
  reg [`BCC_DIV_W-1:0] div_q;
  reg src_lvl_q;
  reg src_prev_q;
  reg gate_lvl_q;
  reg gate_prev_q;

  wire slow_tick;
  wire src_edge;
  reg tick;
  wire g_rise;
  wire g_fall;
  wire g_start;
  wire g_end;
  reg cap;
  wire push;
  wire buf_ready;
  wire gate_now;
  wire gate_act_now;
  wire last_entry;

  // Slow timebase runs free so its phase does not depend on arming.
  // slow timebase divider
  assign slow_tick = (div_q == SLOW_LAST);

  assign src_edge = edge_seen(src_prev_q, src_lvl_q, src_fall_q);

  // Count tick from the selected input; fast timebase ticks every cycle.
  // count input selection
  always @* begin
    case (src_sel_q)
      `BCC_SRC_FAST: tick = 1'b1;
      `BCC_SRC_SLOW: tick = slow_tick;
      `BCC_SRC_SIBLING: tick = src_edge;
      default: tick = src_sel_q[`BCC_SRC_PIN_BIT] ? 1'b0 : src_edge;
    endcase
  end

  // Gate edges seen on the registered gate level.
  assign g_rise = edge_seen(gate_prev_q, gate_lvl_q, `BCC_RISING_EDGE);
  assign g_fall = edge_seen(gate_prev_q, gate_lvl_q, `BCC_FALLING_EDGE);
  assign g_start = gate_low_q ? g_fall : g_rise;
  assign g_end = gate_low_q ? g_rise : g_fall;

  // Gate level on the incoming selection, used only in the arm cycle.
  assign gate_now = FUNC_PIN_I[CAPTURE_INPUT_SELECT_I];
  assign gate_act_now = gate_now ^ CAPTURE_INPUT_EDGE_I;

  // Capture condition per mode.
  always @* begin
    case (mode_q)
      `BCC_MODE_TALLY: cap = g_start;
      `BCC_MODE_INTERVAL: cap = g_start;
      `BCC_MODE_HALF: cap = g_rise | g_fall;
      `BCC_MODE_WIDTH: cap = g_end & run_q;
      default: cap = 1'b0;
    endcase
  end

  // captures enter the buffer in order
  // A capture in an arm or disarm cycle is dropped so runs never mix.
  assign push = ARMED_O & cap & ~RESET_ACTION_I & ~ARM_ACTION_I;
  assign last_entry = (ENTRIES_DONE_O + 24'h000001 >= target_q);

  // Next count and run state while armed.
  always @* begin
    cnt_d = cnt_q;
    run_d = run_q;
    case (mode_q)
      `BCC_MODE_TALLY: begin
        if (gate_lvl_q ^ gate_low_q) begin
          run_d = 1'b1;
        end
        if (run_q && tick && cnt_q != `BCC_CNT_MAX) begin
          cnt_d = cnt_q + 24'h000001;
        end
      end
      `BCC_MODE_WIDTH: begin
        if (g_start) begin
          run_d = 1'b1;
          cnt_d = `BCC_CNT_RST;
        end else if (g_end) begin
          run_d = 1'b0;
        end else if (run_q && tick && cnt_q != `BCC_CNT_MAX) begin
          cnt_d = cnt_q + 24'h000001;
        end
      end
      default: begin
        if (cap) begin
          cnt_d = `BCC_CNT_RST;
        end else if (tick && cnt_q != `BCC_CNT_MAX) begin
          cnt_d = cnt_q + 24'h000001;
        end
      end
    endcase
  end

  // Free-running divider for the slow timebase.
  always @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      div_q <= {`BCC_DIV_W{1'b0}};
    end else if (CE_I) begin
      div_q <= slow_tick ? {`BCC_DIV_W{1'b0}} : div_q + 8'h01;
    end
  end

  // Input sampling; arming preloads both stages so no false edge appears.
  always @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      src_lvl_q <= 1'b0;
      src_prev_q <= 1'b0;
      gate_lvl_q <= 1'b0;
      gate_prev_q <= 1'b0;
    end else if (CE_I) begin
      if (ARM_ACTION_I) begin
        src_lvl_q <= src_level(COUNT_INPUT_SELECT_I, FUNC_PIN_I,
                               SIBLING_TC_I);
        src_prev_q <= src_level(COUNT_INPUT_SELECT_I, FUNC_PIN_I,
                                SIBLING_TC_I);
        gate_lvl_q <= gate_now;
        gate_prev_q <= gate_now;
      end else begin
        src_lvl_q <= src_level(src_sel_q, FUNC_PIN_I, SIBLING_TC_I);
        src_prev_q <= src_lvl_q;
        gate_lvl_q <= FUNC_PIN_I[gate_sel_q];
        gate_prev_q <= gate_lvl_q;
      end
    end
  end

  // Configuration is latched at arming so edits cannot upset a run.
  always @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      mode_q <= `BCC_MODE_TALLY;
      src_sel_q <= `BCC_SRC_FAST;
      src_fall_q <= `BCC_RISING_EDGE;
      gate_sel_q <= 3'h0;
      gate_low_q <= `BCC_ACTIVE_HIGH;
      target_q <= 24'h000001;
    end else if (CE_I && ARM_ACTION_I) begin
      mode_q <= MODE_I;
      src_sel_q <= COUNT_INPUT_SELECT_I;
      src_fall_q <= COUNT_INPUT_EDGE_I;
      gate_sel_q <= CAPTURE_INPUT_SELECT_I;
      gate_low_q <= CAPTURE_INPUT_EDGE_I;
      target_q <= BUF_ENTRIES_I;
    end
  end

  // Arming, counting, capture bookkeeping and self-disarm.
  always @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      ARMED_O <= 1'b0;
      cnt_q <= `BCC_CNT_RST;
      run_q <= 1'b0;
      ENTRIES_DONE_O <= 24'h000000;
      TC_REACHED_O <= 1'b0;
      OVERRUN_O <= 1'b0;
    end else if (CE_I) begin
      if (RESET_ACTION_I) begin
        ARMED_O <= 1'b0;
        run_q <= 1'b0;
      end else if (ARM_ACTION_I) begin
        ARMED_O <= 1'b1;
        cnt_q <= `BCC_CNT_RST;
        ENTRIES_DONE_O <= 24'h000000;
        TC_REACHED_O <= 1'b0;
        OVERRUN_O <= 1'b0;
        if (MODE_I == `BCC_MODE_TALLY || MODE_I == `BCC_MODE_WIDTH) begin
          run_q <= gate_act_now;
        end else begin
          run_q <= 1'b1;
        end
      end else if (ARMED_O) begin
        cnt_q <= cnt_d;
        run_q <= run_d;
        if (cnt_d == `BCC_CNT_MAX) begin
          TC_REACHED_O <= 1'b1;
        end
        if (push && buf_ready) begin
          ENTRIES_DONE_O <= ENTRIES_DONE_O + 24'h000001;
          if (last_entry) begin
            ARMED_O <= 1'b0;
          end
        end else if (push) begin
          OVERRUN_O <= 1'b1;
        end
      end
    end
  end

  // Live count for status, one cycle behind the counter.
  always @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      COUNT_O <= `BCC_CNT_RST;
    end else if (CE_I) begin
      COUNT_O <= cnt_q;
    end
  end

  // The buffer absorbs a receiver stall of up to two words; a capture while it is full is dropped and sets OVERRUN_O.
  // valid held high while the buffer holds a word
  bcc_pair_buf u_buf (
    .clk_i(MCLK_I),
    .arst_n_i(ARST_N_I),
    .ce_i(CE_I),
    .in_data_i(cnt_q),
    .in_valid_i(push),
    .in_ready_o(buf_ready),
    .out_data_o(DATA_O),
    .out_valid_o(DATA_VALID_O),
    .out_ready_i(DATA_READY_I)
  );

endmodule // bcc_counter

// >>> hdl/bcc_pair_buf.v
`timescale 1ns/1ps
`include "bcc_consts.vh"

module bcc_pair_buf (
  // Clock, reset and enable.
  input wire clk_i,
  input wire arst_n_i,
  input wire ce_i,
  // Filling side.
  input wire [`BCC_CNT_W-1:0] in_data_i,
  input wire in_valid_i,
  output wire in_ready_o,
  // Draining side.
  output wire [`BCC_CNT_W-1:0] out_data_o,
  output wire out_valid_o,
  input wire out_ready_i
);

  reg [`BCC_CNT_W-1:0] mem_q [0:1];
  reg wr_ptr_q;
  reg rd_ptr_q;
  reg [1:0] fill_q;
  wire push;
  wire pop;

  // Two entries let the source keep going for one stalled word.
  assign in_ready_o = (fill_q != 2'h2);
  assign out_valid_o = (fill_q != 2'h0);
  assign out_data_o = mem_q[rd_ptr_q];
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;

  // Pointers and fill level; push and pop may coincide.
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mem_q[0] <= `BCC_CNT_RST;
      mem_q[1] <= `BCC_CNT_RST;
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      fill_q <= 2'h0;
    end else if (ce_i) begin
      if (push) begin
        mem_q[wr_ptr_q] <= in_data_i;
        wr_ptr_q <= ~wr_ptr_q;
      end
      if (pop) begin
        rd_ptr_q <= ~rd_ptr_q;
      end
      if (push && !pop) begin
        fill_q <= fill_q + 2'h1;
      end else if (pop && !push) begin
        fill_q <= fill_q - 2'h1;
      end
    end
  end

endmodule // bcc_pair_buf

// >>> testbench/bcc_counter_chk.sv
`timescale 1ns/1ps
module bcc_counter_chk (
  // Clock and reset.
  input wire MCLK_I,
  input wire ARST_N_I,
  // Watched inputs.
  input wire CE_I,
  input wire ARM_ACTION_I,
  input wire RESET_ACTION_I,
  input wire DATA_READY_I,
  // Watched outputs.
  input wire ARMED_O,
  input wire OVERRUN_O,
  input wire DATA_VALID_O,
  input wire [23:0] DATA_O,
  input wire [23:0] ENTRIES_DONE_O
);
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (!ARST_N_I);
  // An arm that the disarm action does not override.
  wire arm_w = CE_I && ARM_ACTION_I && !RESET_ACTION_I;
  a_arm_starts_run: assert property (
    arm_w |=> ARMED_O && ENTRIES_DONE_O == 24'h000000 && !OVERRUN_O)
    else $error("arm did not start a clean run");
  a_disarm_action: assert property (
    CE_I && RESET_ACTION_I |=> !ARMED_O)
    else $error("disarm action left the counter armed");
  a_armed_holds: assert property (
    ARMED_O && !(CE_I && RESET_ACTION_I) |=>
    ARMED_O || $changed(ENTRIES_DONE_O))
    else $error("armed dropped without a final entry");
  a_word_held: assert property (
    DATA_VALID_O && !DATA_READY_I && CE_I |=>
    DATA_VALID_O && $stable(DATA_O))
    else $error("stalled word changed or vanished");
  a_entry_has_word: assert property (
    $changed(ENTRIES_DONE_O) && ENTRIES_DONE_O != 24'h000000 |->
    DATA_VALID_O)
    else $error("accepted entry without a word");
  a_entry_step: assert property (
    !arm_w |=> ENTRIES_DONE_O == $past(ENTRIES_DONE_O) ||
    ENTRIES_DONE_O == $past(ENTRIES_DONE_O) + 24'h000001)
    else $error("entry count jumped");
  a_ce_freezes: assert property (
    !CE_I |=> $stable(ARMED_O) && $stable(ENTRIES_DONE_O))
    else $error("state moved with the enable low");
  a_overrun_sticky: assert property (
    OVERRUN_O && !arm_w |=> OVERRUN_O)
    else $error("overrun flag cleared without arm");
endmodule // bcc_counter_chk

bind bcc_counter bcc_counter_chk chk_u (.MCLK_I(MCLK_I),
  .ARST_N_I(ARST_N_I), .CE_I(CE_I), .ARM_ACTION_I(ARM_ACTION_I),
  .RESET_ACTION_I(RESET_ACTION_I), .DATA_READY_I(DATA_READY_I),
  .ARMED_O(ARMED_O), .OVERRUN_O(OVERRUN_O), .DATA_VALID_O(DATA_VALID_O),
  .DATA_O(DATA_O), .ENTRIES_DONE_O(ENTRIES_DONE_O));

// >>> testbench/bcc_sig_src.sv
`timescale 1ns/1ps
module bcc_sig_src (
  // Clock.
  input wire clk_i,
  // Pattern control.
  input wire run_i,
  input wire [15:0] hi_i,
  input wire [15:0] lo_i,
  input wire [7:0] half_i,
  // Connector side.
  output reg [7:0] pins_o,
  output reg sib_o
);
  reg [15:0] g_q = 16'h0000;
  reg [7:0] s_q = 8'h00;
  initial pins_o = 8'h00;
  initial sib_o = 1'b0;
  // Gate on pin two, low phase first; the timebase stands still when idle.
  always @(negedge clk_i) begin
    if (!run_i) begin
      g_q <= 16'h0000;
      s_q <= 8'h00;
      pins_o <= 8'h00;
      sib_o <= 1'b0;
    end else begin
      g_q <= (g_q == hi_i + lo_i - 16'h0001) ? 16'h0000 : g_q + 16'h0001;
      pins_o[2] <= (g_q >= lo_i);
      if (half_i != 8'h00 && s_q == half_i - 8'h01) begin
        s_q <= 8'h00;
        pins_o[5] <= ~pins_o[5];
        sib_o <= ~sib_o;
      end else begin
        s_q <= s_q + 8'h01;
      end
    end
  end
endmodule // bcc_sig_src

// >>> testbench/tb.sv
`timescale 1ns/1ps
module tb;
  reg MCLK_I = 1'b0;
  reg ARST_N_I = 1'b0;
  reg CE_I = 1'b1;
  reg [1:0] MODE_I = 2'h0;
  reg [3:0] COUNT_INPUT_SELECT_I = 4'h8;
  reg COUNT_INPUT_EDGE_I = 1'b0;
  reg [2:0] CAPTURE_INPUT_SELECT_I = 3'h2;
  reg CAPTURE_INPUT_EDGE_I = 1'b0;
  reg [23:0] BUF_ENTRIES_I = 24'h000004;
  reg ARM_ACTION_I = 1'b0;
  reg RESET_ACTION_I = 1'b0;
  reg DATA_READY_I = 1'b1;
  wire [7:0] FUNC_PIN_I;
  wire SIBLING_TC_I, ARMED_O, TC_REACHED_O, OVERRUN_O, DATA_VALID_O;
  wire [23:0] COUNT_O, ENTRIES_DONE_O, DATA_O;
  reg run = 1'b0;
  reg [15:0] hi = 16'h0000;
  reg [15:0] lo = 16'h0000;
  reg [7:0] half = 8'h00;
  reg [23:0] got[$];
  integer n_fail = 0;
  integer tests_run = 0;

  always #25 MCLK_I = ~MCLK_I;

  bcc_counter dut_u (.MCLK_I(MCLK_I), .ARST_N_I(ARST_N_I), .CE_I(CE_I),
    .MODE_I(MODE_I), .COUNT_INPUT_SELECT_I(COUNT_INPUT_SELECT_I),
    .COUNT_INPUT_EDGE_I(COUNT_INPUT_EDGE_I),
    .CAPTURE_INPUT_SELECT_I(CAPTURE_INPUT_SELECT_I),
    .CAPTURE_INPUT_EDGE_I(CAPTURE_INPUT_EDGE_I),
    .BUF_ENTRIES_I(BUF_ENTRIES_I), .ARM_ACTION_I(ARM_ACTION_I),
    .RESET_ACTION_I(RESET_ACTION_I), .FUNC_PIN_I(FUNC_PIN_I),
    .SIBLING_TC_I(SIBLING_TC_I), .ARMED_O(ARMED_O), .COUNT_O(COUNT_O),
    .ENTRIES_DONE_O(ENTRIES_DONE_O), .TC_REACHED_O(TC_REACHED_O),
    .OVERRUN_O(OVERRUN_O), .DATA_O(DATA_O), .DATA_VALID_O(DATA_VALID_O),
    .DATA_READY_I(DATA_READY_I));

  bcc_sig_src src_u (.clk_i(MCLK_I), .run_i(run), .hi_i(hi), .lo_i(lo),
    .half_i(half), .pins_o(FUNC_PIN_I), .sib_o(SIBLING_TC_I));

  // Words leave the buffer at edges where valid meets ready.
  always @(posedge MCLK_I)
    if (CE_I === 1'b1 && DATA_VALID_O === 1'b1 && DATA_READY_I === 1'b1)
      got.push_back(DATA_O);

  task chk(input string name, input [23:0] exp, input [23:0] seen);
    tests_run = tests_run + 1;
    if (seen !== exp) begin
      n_fail = n_fail + 1;
      $display("ERROR %0s expected %h seen %h", name, exp, seen);
    end
  endtask

  task report_and_stop;
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task cyc(input integer n);
    repeat (n) @(negedge MCLK_I);
  endtask

  task pulse_arm;
    ARM_ACTION_I = 1'b1;
    cyc(1);
    ARM_ACTION_I = 1'b0;
  endtask

  // Results are taken once the counter shows itself disarmed, or after 5000 cycles.
  task run_case(input [1:0] m, input [3:0] s, input se, input ge,
                input [15:0] h, input [15:0] l, input [7:0] hf,
                input [23:0] exp);
    integer i;
    reg [23:0] v;
    got.delete();
    MODE_I = m;
    COUNT_INPUT_SELECT_I = s;
    COUNT_INPUT_EDGE_I = se;
    CAPTURE_INPUT_EDGE_I = ge;
    hi = h;
    lo = l;
    half = hf;
    pulse_arm();
    run = 1'b1;
    for (i = 0; i < 5000 && ARMED_O !== 1'b0; i = i + 1) cyc(1);
    run = 1'b0;
    cyc(3);
    chk("armed", 24'h0, {23'h0, ARMED_O});
    chk("tc", 24'h0, {23'h0, TC_REACHED_O});
    chk("entries", 24'h4, ENTRIES_DONE_O);
    chk("words", 24'h4, got.size());
    // The first two words may be partial, so only later ones are judged.
    for (i = 2; i < 4; i = i + 1) begin
      v = (m == 2'h0) ? got[i] - got[i-1] : got[i];
      // The slow tick may fall in the capture cycle and be dropped.
      if (s == 4'h9 && v == exp - 24'h1) v = exp;
      chk("value", exp, v);
    end
    $display("test mode %0d source %0d done", m, s);
  endtask

  initial begin
    repeat (2) @(posedge MCLK_I);
    @(negedge MCLK_I) ARST_N_I = 1'b1;
    cyc(1);
    run_case(2'h0, 4'h5, 1'b0, 1'b0, 16'd8, 16'd8, 8'd2, 24'd4);
    run_case(2'h0, 4'hA, 1'b1, 1'b1, 16'd8, 16'd8, 8'd2, 24'd4);
    run_case(2'h1, 4'h8, 1'b0, 1'b0, 16'd7, 16'd5, 8'd0, 24'd11);
    run_case(2'h1, 4'h8, 1'b0, 1'b1, 16'd7, 16'd5, 8'd0, 24'd11);
    run_case(2'h2, 4'h8, 1'b0, 1'b0, 16'd6, 16'd6, 8'd0, 24'd5);
    run_case(2'h3, 4'h8, 1'b0, 1'b0, 16'd6, 16'd10, 8'd0, 24'd5);
    run_case(2'h3, 4'h8, 1'b0, 1'b1, 16'd6, 16'd10, 8'd0, 24'd9);
    run_case(2'h1, 4'h9, 1'b0, 1'b0, 16'd300, 16'd300, 8'd0, 24'd3);
    // Receiver stalls: two words fit, later captures are refused.
    got.delete();
    DATA_READY_I = 1'b0;
    MODE_I = 2'h1;
    COUNT_INPUT_SELECT_I = 4'h8;
    hi = 16'd5;
    lo = 16'd5;
    pulse_arm();
    run = 1'b1;
    CE_I = 1'b0;
    cyc(3);
    CE_I = 1'b1;
    cyc(1);
    chk("count", 24'h0, COUNT_O);
    cyc(1);
    chk("count", 24'h1, COUNT_O);
    cyc(58);
    chk("entries", 24'h2, ENTRIES_DONE_O);
    chk("overrun", 24'h1, {23'h0, OVERRUN_O});
    chk("armed", 24'h1, {23'h0, ARMED_O});
    RESET_ACTION_I = 1'b1;
    cyc(1);
    RESET_ACTION_I = 1'b0;
    run = 1'b0;
    chk("armed", 24'h0, {23'h0, ARMED_O});
    DATA_READY_I = 1'b1;
    cyc(4);
    chk("words", 24'h2, got.size());
    $display("test stall done");
    report_and_stop();
  end

  // Watchdog well beyond the expected run length.
  initial begin
    #1000000;
    n_fail = n_fail + 1;
    report_and_stop();
  end
endmodule // tb
